// ===== include/ttxr_consts.svh
`ifndef TTXR_CONSTS_SVH
`define TTXR_CONSTS_SVH

// register select values
`define TTXR_SEL_DATA      1'h0
`define TTXR_SEL_CTRL      1'h1

// control register a fields
`define TTXR_CRA_TONE_EN   0
`define TTXR_CRA_CP_SEL    1
`define TTXR_CRA_IRQ_EN    2
`define TTXR_CRA_PTR       3

// control register b fields
`define TTXR_CRB_BURST_N   0
`define TTXR_CRB_TEST      1
`define TTXR_CRB_SINGLE    2
`define TTXR_CRB_COLUMN    3

// status fields
`define TTXR_ST_IRQ        0
`define TTXR_ST_TX_EMPTY   1
`define TTXR_ST_RX_FULL    2
`define TTXR_ST_ABSENT     3

// reset values
`define TTXR_CRA_RST       4'h0
`define TTXR_CRB_RST       4'h0
`define TTXR_DIGIT_RST     4'h0

// timing
`define TTXR_CLK_MHZ       100
`define TTXR_BURST_MS      51
`define TTXR_CP_BURST_MS   102
`define TTXR_CYC_PER_MS    (`TTXR_CLK_MHZ * 1000)
`define TTXR_BURST_CYC     (`TTXR_BURST_MS * `TTXR_CYC_PER_MS)
`define TTXR_CP_BURST_CYC  (`TTXR_CP_BURST_MS * `TTXR_CYC_PER_MS)

`endif

// ===== include/ttxr_pkg.sv
package ttxr_pkg;

  typedef enum logic [1:0] {
    TTXR_IDLE  = 2'b00,
    TTXR_BURST = 2'b01,
    TTXR_PAUSE = 2'b10
  } ttxr_burst_t;

endpackage : ttxr_pkg

// ===== verilog/ttxr_host_regs.sv
// What this block does
// - select low: data registers; high: control/status
// - pointer bit steers next control write to b
// - receive digit read-only, last validated code
// - transmit digit write-only, selects tone pair
// - control a b0 gates all tone output
// - control a b1 selects call progress, blocks digits
// - call progress plus irq: pin follows tone
// - irq enable: pin low on digit or ready
// - pin only pulls low or floats
// - burst mode: burst, equal pause, then ready
// - call progress doubles burst and pause length
// - non-burst tone follows tone enable bit
// - test mode: pin mirrors settled absence flag
// - control b b2 selects single tone
// - control b b3 selects column or row
// - status b0 is b1 or b2, read clears
// - tx empty after pause, read clears, burst only
// - rx full on digit latch, read clears
// - absence flag set on absence, cleared on digit
// - no wait states for a 16 MHz host
// - tx empty not before 100 or 200 ms
// - receive digit held until next valid digit
`timescale 1ns/1ns
`default_nettype none
`include "ttxr_consts.svh"

module ttxr_host_regs #(
  parameter int BURST_CYC    = `TTXR_BURST_CYC,
  parameter int CP_BURST_CYC = `TTXR_CP_BURST_CYC,
  parameter int CNT_W        = 24
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       chip_select_n,
  input  wire logic       register_select_line,
  input  wire logic       write_strobe_n,
  input  wire logic       read_strobe_n,
  input  wire logic [3:0] data_in,
  output logic      [3:0] data_out,
  output logic            data_oe,
  output logic            interrupt_or_tone_pin_val,
  output logic            interrupt_or_tone_pin_oe,
  input  wire logic       digit_valid,
  input  wire logic [3:0] digit_code,
  input  wire logic       absence_valid,
  input  wire logic       cp_tone_level,
  output logic            tone_on,
  output logic      [3:0] tone_code,
  output logic            single_tone,
  output logic            column_tone
);
  import ttxr_pkg::*;

  if (CNT_W < 2 || CNT_W > 31 || BURST_CYC < 1 || CP_BURST_CYC < 1 ||
      CP_BURST_CYC >= (1 << CNT_W) || BURST_CYC >= (1 << CNT_W)) begin : g_chk
    $error("ttxr_host_regs: burst counts do not fit the counter");
  end

  logic [3:0]  control_a_r;
  logic [3:0]  control_b_r;
  logic        second_control_pointer_r;
  logic [3:0]  transmit_digit_r;
  logic [3:0]  receive_digit_r;
  logic        tx_empty_r;
  logic        rx_full_r;
  logic        settled_absence_flag_r;
  logic        wr_act_r;
  logic        rd_act_r;
  logic        wr_sel_r;
  logic        rd_sel_r;
  logic [3:0]  wr_data_r;
  ttxr_burst_t burst_st_r;
  ttxr_burst_t burst_st_nxt;
  logic [CNT_W-1:0] burst_cnt_r;
  logic [CNT_W-1:0] burst_cnt_nxt;

  logic wr_now;
  logic rd_now;
  logic wr_done;
  logic rd_done;
  logic tx_write;
  logic ctrl_write;
  logic status_read;
  logic burst_mode;
  logic cp_mode;
  logic digit_take;
  logic pause_end;
  logic [CNT_W-1:0] phase_len;
  logic [3:0] status_val;

  // strobes count only with chip select
  assign wr_now      = !chip_select_n && !write_strobe_n;
  assign rd_now      = !chip_select_n && !read_strobe_n;
  // writes commit on the trailing edge, using data from the last active edge
  assign wr_done     = wr_act_r && !wr_now;
  assign rd_done     = rd_act_r && !rd_now;
  assign tx_write    = wr_done && (wr_sel_r == `TTXR_SEL_DATA);
  assign ctrl_write  = wr_done && (wr_sel_r == `TTXR_SEL_CTRL);
  assign status_read = rd_done && (rd_sel_r == `TTXR_SEL_CTRL);
  assign burst_mode  = !control_b_r[`TTXR_CRB_BURST_N];
  assign cp_mode     = control_a_r[`TTXR_CRA_CP_SEL];
  assign digit_take  = digit_valid && !cp_mode;
  assign phase_len   = cp_mode ? CNT_W'(CP_BURST_CYC - 1)
                               : CNT_W'(BURST_CYC - 1);
  assign pause_end   = (burst_st_r == TTXR_PAUSE) && (burst_cnt_r == '0);

  always_comb begin
    status_val = 4'h0;
    status_val[`TTXR_ST_IRQ]      = tx_empty_r || rx_full_r;
    status_val[`TTXR_ST_TX_EMPTY] = tx_empty_r;
    status_val[`TTXR_ST_RX_FULL]  = rx_full_r;
    status_val[`TTXR_ST_ABSENT]   = settled_absence_flag_r;
  end

  // bus access tracking
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_act_r  <= 1'b0;
      rd_act_r  <= 1'b0;
      wr_sel_r  <= 1'b0;
      rd_sel_r  <= 1'b0;
      wr_data_r <= 4'h0;
    end else begin
      wr_act_r <= wr_now;
      rd_act_r <= rd_now;
      if (wr_now) begin
        wr_sel_r  <= register_select_line;
        wr_data_r <= data_in;
      end
      if (rd_now) begin
        rd_sel_r <= register_select_line;
      end
    end
  end

  // read data: one clock after the strobe, well inside a 16 MHz cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      data_out <= 4'h0;
      data_oe  <= 1'b0;
    end else begin
      data_oe <= rd_now;
      if (register_select_line == `TTXR_SEL_CTRL) begin
        data_out <= status_val;
      end else begin
        data_out <= receive_digit_r;
      end
    end
  end

  // control registers sharing one address
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      control_a_r              <= `TTXR_CRA_RST;
      control_b_r              <= `TTXR_CRB_RST;
      second_control_pointer_r <= 1'b0;
    end else if (ctrl_write) begin
      if (second_control_pointer_r) begin
        control_b_r              <= wr_data_r;
        second_control_pointer_r <= 1'b0;
      end else begin
        control_a_r              <= wr_data_r;
        second_control_pointer_r <= wr_data_r[`TTXR_CRA_PTR];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      transmit_digit_r <= `TTXR_DIGIT_RST;
    end else if (tx_write) begin
      transmit_digit_r <= wr_data_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      receive_digit_r <= `TTXR_DIGIT_RST;
    end else if (digit_take) begin
      receive_digit_r <= digit_code;
    end
  end

  // burst sequencer
  always_comb begin
    burst_st_nxt  = burst_st_r;
    burst_cnt_nxt = burst_cnt_r;
    case (burst_st_r)
      TTXR_IDLE: begin
        burst_cnt_nxt = '0;
      end
      TTXR_BURST: begin
        if (burst_cnt_r == '0) begin
          burst_st_nxt  = TTXR_PAUSE;
          burst_cnt_nxt = phase_len;
        end else begin
          burst_cnt_nxt = burst_cnt_r - CNT_W'(1);
        end
      end
      TTXR_PAUSE: begin
        if (burst_cnt_r == '0) begin
          burst_st_nxt = TTXR_IDLE;
        end else begin
          burst_cnt_nxt = burst_cnt_r - CNT_W'(1);
        end
      end
      default: begin
        burst_st_nxt  = TTXR_IDLE;
        burst_cnt_nxt = '0;
      end
    endcase
    // a new digit restarts the burst; leaving burst mode aborts it
    if (tx_write && burst_mode) begin
      burst_st_nxt  = TTXR_BURST;
      burst_cnt_nxt = phase_len;
    end else if (!burst_mode) begin
      burst_st_nxt  = TTXR_IDLE;
      burst_cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      burst_st_r  <= TTXR_IDLE;
      burst_cnt_r <= '0;
    end else begin
      burst_st_r  <= burst_st_nxt;
      burst_cnt_r <= burst_cnt_nxt;
    end
  end

  // status flags: a set wins over a same-cycle clear, except a transmit write or burst mode off clears tx empty
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_empty_r <= 1'b0;
    end else if (!burst_mode) begin
      tx_empty_r <= 1'b0;
    end else if (pause_end && !tx_write) begin
      tx_empty_r <= 1'b1;
    end else if (status_read || tx_write) begin
      tx_empty_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_full_r <= 1'b0;
    end else if (digit_take) begin
      rx_full_r <= 1'b1;
    end else if (status_read) begin
      rx_full_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      settled_absence_flag_r <= 1'b0;
    end else if (absence_valid) begin
      settled_absence_flag_r <= 1'b1;
    end else if (digit_take) begin
      settled_absence_flag_r <= 1'b0;
    end
  end

  // transmitter steering
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tone_on     <= 1'b0;
      tone_code   <= `TTXR_DIGIT_RST;
      single_tone <= 1'b0;
      column_tone <= 1'b0;
    end else begin
      if (burst_mode) begin
        tone_on <= control_a_r[`TTXR_CRA_TONE_EN] &&
                   (burst_st_nxt == TTXR_BURST);
      end else begin
        tone_on <= control_a_r[`TTXR_CRA_TONE_EN];
      end
      tone_code   <= transmit_digit_r;
      single_tone <= control_b_r[`TTXR_CRB_SINGLE];
      column_tone <= control_b_r[`TTXR_CRB_COLUMN];
    end
  end

  // open drain: the level is never driven, only the enable moves
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      interrupt_or_tone_pin_val <= 1'b0;
      interrupt_or_tone_pin_oe  <= 1'b0;
    end else begin
      interrupt_or_tone_pin_val <= 1'b0;
      if (cp_mode) begin
        interrupt_or_tone_pin_oe <= control_a_r[`TTXR_CRA_IRQ_EN] &&
                                    !cp_tone_level;
      end else if (control_b_r[`TTXR_CRB_TEST]) begin
        interrupt_or_tone_pin_oe <= !settled_absence_flag_r;
      end else begin
        interrupt_or_tone_pin_oe <= control_a_r[`TTXR_CRA_IRQ_EN] &&
                                    (tx_empty_r || rx_full_r);
      end
    end
  end

endmodule : ttxr_host_regs
`default_nettype wire

// ===== sim/ttxr_host_regs_chk.sv
`timescale 1ns/1ns
`default_nettype none
module ttxr_host_regs_chk (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       chip_select_n,
  input wire logic       register_select_line,
  input wire logic       write_strobe_n,
  input wire logic       read_strobe_n,
  input wire logic [3:0] data_out,
  input wire logic       data_oe,
  input wire logic       interrupt_or_tone_pin_val,
  input wire logic       tone_on,
  input wire logic [3:0] tone_code,
  input wire logic       single_tone
);
  wire rd  = !chip_select_n && !read_strobe_n;
  wire wr  = !chip_select_n && !write_strobe_n;
  wire txw = wr && !register_select_line;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_rd_ans; rd |=> data_oe; endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read not answered");
  property p_oe_cause; data_oe |-> $past(rd); endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("bus driven without read");
  property p_no_cs; $past(chip_select_n) |-> !data_oe; endproperty
  a_no_cs: assert property (p_no_cs)
    else $error("bus driven while deselected");
  property p_st_b0;
    data_oe && $past(register_select_line) |-> data_out[0] == |data_out[2:1];
  endproperty
  a_st_b0: assert property (p_st_b0)
    else $error("status b0 not b1 or b2");
  property p_tx_code;
    $changed(tone_code) |-> $past(txw, 2) || $past(txw, 3) || $past(txw, 4);
  endproperty
  a_tx_code: assert property (p_tx_code)
    else $error("tone code changed without data write");
  property p_st_sel;
    $changed(single_tone) |-> $past(wr, 2) || $past(wr, 3) || $past(wr, 4);
  endproperty
  a_st_sel: assert property (p_st_sel)
    else $error("tone shape changed without write");
  property p_tone_rise;
    $rose(tone_on) |-> $past(wr, 2) || $past(wr, 3) || $past(wr, 4);
  endproperty
  a_tone_rise: assert property (p_tone_rise)
    else $error("tone started without write");
  property p_pin_od; interrupt_or_tone_pin_val == 1'h0; endproperty
  a_pin_od: assert property (p_pin_od)
    else $error("pin driven high");
endmodule : ttxr_host_regs_chk
bind ttxr_host_regs ttxr_host_regs_chk u_chk (
  .clk_sys, .rst, .chip_select_n, .register_select_line, .write_strobe_n,
  .read_strobe_n, .data_out, .data_oe, .interrupt_or_tone_pin_val, .tone_on,
  .tone_code, .single_tone);
`default_nettype wire

// ===== sim/ttxr_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module ttxr_host_model (
  input  wire logic       clk_sys,
  input  wire logic [3:0] data_out,
  input  wire logic       data_oe,
  input  wire logic       pin_oe,
  output logic            pin_level,
  output logic            cs_n,
  output logic            rs,
  output logic            wr_n,
  output logic            rd_n,
  output logic      [3:0] dq
);
  logic cs_off = 1'h0;
  assign pin_level = !pin_oe;
  initial begin
    cs_n = 1'h1;
    rs   = 1'h0;
    wr_n = 1'h1;
    rd_n = 1'h1;
    dq   = 4'h0;
  end
  // one-cycle strobe, no wait states
  task automatic acc(input logic w, input logic s, input logic [3:0] d,
                     output logic [3:0] q);
    @(negedge clk_sys);
    cs_n = cs_off;
    rs   = s;
    dq   = d;
    wr_n = !w;
    rd_n = w;
    @(negedge clk_sys);
    q    = data_oe ? data_out : ~d;
    cs_n = 1'h1;
    wr_n = 1'h1;
    rd_n = 1'h1;
    dq   = ~d;
  endtask : acc
  task automatic init(output logic [3:0] q);
    logic [3:0] t;
    acc(1'h0, 1'h1, 4'h0, t);
    acc(1'h1, 1'h1, 4'h0, t);
    acc(1'h1, 1'h1, 4'h0, t);
    acc(1'h1, 1'h1, 4'h8, t);
    acc(1'h1, 1'h1, 4'h0, t);
    acc(1'h0, 1'h1, 4'h0, q);
  endtask : init
endmodule : ttxr_host_model
`default_nettype wire

// ===== sim/ttxr_host_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module ttxr_host_regs_tb;
  typedef struct {logic [3:0] b; logic [3:0] d;} ttxr_row_t;
  localparam int BL = 20;
  logic       clk_sys = 1'h0;
  logic       rst = 1'h1;
  logic       digit_valid = 1'h0;
  logic       absence_valid = 1'h0;
  logic       cp_tone_level = 1'h1;
  logic [3:0] digit_code = 4'h0;
  logic [3:0] q;
  wire        chip_select_n, register_select_line, write_strobe_n;
  wire        read_strobe_n, data_oe, interrupt_or_tone_pin_val;
  wire        interrupt_or_tone_pin_oe, tone_on, single_tone, column_tone;
  wire        pin_level;
  wire  [3:0] data_in, data_out, tone_code;
  int         err_total = 0;
  int         tests_run = 0;
  int         cyc = 0;
  int         n = 0;
  ttxr_row_t  rows [4] = '{'{4'h0, 4'h7}, '{4'h5, 4'h0}, '{4'hC, 4'hF},
                           '{4'h9, 4'hA}};
  ttxr_host_regs #(.BURST_CYC(BL), .CP_BURST_CYC(2 * BL)) dut (
    .clk_sys, .rst, .chip_select_n, .register_select_line, .write_strobe_n,
    .read_strobe_n, .data_in, .data_out, .data_oe, .interrupt_or_tone_pin_val,
    .interrupt_or_tone_pin_oe, .digit_valid, .digit_code, .absence_valid,
    .cp_tone_level, .tone_on, .tone_code, .single_tone, .column_tone);
  ttxr_host_model h (
    .clk_sys, .data_out, .data_oe, .pin_oe(interrupt_or_tone_pin_oe),
    .pin_level, .cs_n(chip_select_n), .rs(register_select_line),
    .wr_n(write_strobe_n), .rd_n(read_strobe_n), .dq(data_in));
  always #5 clk_sys = !clk_sys;
  always @(posedge clk_sys) begin
    n <= n + int'(tone_on);
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      final_report();
    end
  end
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic pulse(ref logic s);
    @(negedge clk_sys);
    s = 1'h1;
    @(negedge clk_sys);
    s = 1'h0;
    repeat (2) @(negedge clk_sys);
  endtask : pulse
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  initial begin
    repeat (8) @(negedge clk_sys);
    rst = 1'h0;
    chk({tone_on, single_tone, column_tone, interrupt_or_tone_pin_oe}, 4'h0);
    chk(tone_code, 4'h0);
    h.init(q);
    chk(q & 4'h3, 4'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      h.acc(1'h1, 1'h1, 4'h9, q);
      h.acc(1'h1, 1'h1, rows[i].b, q);
      h.acc(1'h1, 1'h0, rows[i].d, q);
      repeat (2) @(negedge clk_sys);
      chk({2'h0, column_tone, single_tone}, {2'h0, rows[i].b[3:2]});
      chk(tone_code, rows[i].d);
      chk({3'h0, tone_on}, 4'h1);
      $display("test row %0d done", i);
    end
    for (int m = 0; m < 2; m++) begin
      h.acc(1'h1, 1'h1, m ? 4'hB : 4'h9, q);
      h.acc(1'h1, 1'h1, 4'h0, q);
      repeat (2) @(negedge clk_sys);
      n = 0;
      h.acc(1'h1, 1'h0, 4'h3, q);
      h.acc(1'h0, 1'h1, 4'h0, q);
      chk(q & 4'h2, 4'h0);
      repeat (60 * (m + 1)) @(negedge clk_sys);
      chk(4'(n), 4'(BL * (m + 1)));
      chk(4'(n >> 4), 4'((BL * (m + 1)) >> 4));
      h.acc(1'h0, 1'h1, 4'h0, q);
      chk(q & 4'h3, 4'h3);
      $display("test burst %0d done", m);
    end
    h.acc(1'h0, 1'h1, 4'h0, q);
    chk(q & 4'h3, 4'h0);
    h.acc(1'h1, 1'h1, 4'h4, q);
    pulse(absence_valid);
    h.acc(1'h0, 1'h1, 4'h0, q);
    chk(q, 4'h8);
    digit_code = 4'hD;
    pulse(digit_valid);
    chk({3'h0, pin_level}, 4'h0);
    h.acc(1'h0, 1'h1, 4'h0, q);
    chk(q, 4'h5);
    h.acc(1'h0, 1'h0, 4'h0, q);
    chk(q, 4'hD);
    h.acc(1'h0, 1'h1, 4'h0, q);
    chk({q[2:0], pin_level}, 4'h1);
    $display("test receive done");
    h.acc(1'h1, 1'h1, 4'h6, q);
    digit_code = 4'h2;
    pulse(digit_valid);
    cp_tone_level = 1'h0;
    repeat (3) @(negedge clk_sys);
    chk({3'h0, pin_level}, 4'h0);
    cp_tone_level = 1'h1;
    repeat (3) @(negedge clk_sys);
    chk({3'h0, pin_level}, 4'h1);
    h.acc(1'h0, 1'h0, 4'h0, q);
    chk(q, 4'hD);
    h.cs_off = 1'h1;
    h.acc(1'h1, 1'h0, 4'h6, q);
    h.cs_off = 1'h0;
    repeat (3) @(negedge clk_sys);
    chk(tone_code, 4'h3);
    $display("test call progress done");
    h.acc(1'h1, 1'h1, 4'h8, q);
    h.acc(1'h1, 1'h1, 4'h3, q);
    repeat (2) @(negedge clk_sys);
    chk({3'h0, pin_level}, 4'h0);
    pulse(absence_valid);
    h.acc(1'h1, 1'h1, 4'h1, q);
    repeat (2) @(negedge clk_sys);
    chk({2'h0, tone_on, pin_level}, 4'h3);
    h.acc(1'h0, 1'h1, 4'h0, q);
    chk(q, 4'h8);
    h.acc(1'h1, 1'h1, 4'h0, q);
    repeat (2) @(negedge clk_sys);
    chk({3'h0, tone_on}, 4'h0);
    $display("test mode done");
    rst = 1'h1;
    repeat (2) @(negedge clk_sys);
    rst = 1'h0;
    chk(tone_code, 4'h0);
    h.acc(1'h0, 1'h1, 4'h0, q);
    chk(q, 4'h0);
    $display("test mid reset done");
    final_report();
  end
endmodule : ttxr_host_regs_tb
`default_nettype wire
